// >>> hw/scs_exec.sv
// Shift, compare and store-forming execution stage, one cycle registered.
// Assumes operands come from the register file on the same clock.
//
// What this block does
// - Right doubleword store on little-endian memory sends type 7 minus addr[2:0] and offset addr[2:0].
// - Right doubleword store in 32-bit user or supervisor mode raises reserved instruction instead.
// - Halfword store adds sign-extended offset to base and writes the low halfword of the source.
// - Halfword store to an odd address raises address error and does not write.
// - Immediate left shift moves the source left by the amount field, zero-filling low bits.
// - In 64-bit mode left shifts sign-extend bit 31 of the word result, even for zero shift.
// - Left shifts yield a valid word result for any 64-bit source and never trap.
// - Variable left shift uses only the low five bits of the first source as count.
// - Signed register compare writes 1 when first is less than second, else 0.
// - Signed immediate compare uses the sign-extended immediate.
// - Unsigned immediate compare sign-extends the immediate then compares unsigned.
// - Unsigned register compare writes 1 when first is below second, else 0.
// - Compares are exact despite subtraction overflow and never trap on overflow.
// - Immediate arithmetic right shift fills high bits with bit 31, sign-extended in 64-bit mode.
// - Variable arithmetic right shift uses the low five bits of the first source as count.
`timescale 1ns/1ps
module scs_exec
  import scs_pkg::*;
(
  input wire logic clk_sys, // Core clock, 40 MHz.
  input wire logic rstn, // Synchronous reset, active low.
  input wire logic issue_valid, // Instruction word is valid this cycle.
  input wire logic [31:0] instr, // Instruction word.
  input wire logic [63:0] first_source_data, // Value of first source register.
  input wire logic [63:0] second_source_data, // Value of second source register.
  input wire logic mode_64, // Core runs in 64-bit mode.
  input wire logic mode_kernel, // Core runs in kernel mode.
  input wire logic memory_big_endian_flag, // Memory is big-endian.
  output logic result_valid, // Result register write is valid.
  output logic [63:0] result, // Result for the destination register.
  output logic store_valid, // Store request toward memory.
  output logic [63:0] store_addr, // Effective address of the store.
  output logic [63:0] store_data, // Byte-lane aligned store data.
  output logic [2:0] store_type, // Access type sent to memory.
  output logic [2:0] store_offset, // Offset sent to memory.
  output logic exc_addr_error, // Address error exception pulse.
  output logic exc_reserved // Reserved instruction exception pulse.
);

  ////////////////////////////////////////////////////////////////////////////
  // Extension of a word result to the register width: sign-extended in 64-bit mode, zero-extended otherwise.
  function automatic logic [63:0] word_ext(input logic [31:0] w, input logic m64);
    word_ext = m64 ? {{32{w[31]}}, w} : {32'h0, w};
  endfunction

  // Field decode.
  wire [5:0] opcode = instr[OPC_LSB +: 6];
  wire [5:0] funct = instr[5:0];
  wire [4:0] shift_amount_field = instr[SA_LSB +: 5];
  wire [63:0] imm_sext = {{48{instr[15]}}, instr[15:0]};
  wire is_special = issue_valid && (opcode == OP_SPECIAL);
  wire is_shl_imm = is_special && (funct == FN_SHL_IMM);
  wire is_shl_var = is_special && (funct == FN_SHL_VAR);
  wire is_sra_imm = is_special && (funct == FN_SRA_IMM);
  wire is_sra_var = is_special && (funct == FN_SRA_VAR);
  wire is_slt = is_special && (funct == FN_SLT);
  wire is_less_than_unsigned_op = is_special && (funct == FN_LESS_THAN_UNSIGNED_OP);
  wire is_less_than_signed_imm_op = issue_valid && (opcode == OP_SLT_IMM);
  wire is_less_than_unsigned_imm_op = issue_valid && (opcode == OP_LESS_THAN_UNSIGNED_OP_IMM);
  wire is_sh = issue_valid && (opcode == OP_STORE_HALF);
  wire is_sdr = issue_valid && (opcode == OP_STORE_DBL_RIGHT);

  ////////////////////////////////////////////////////////////////////////////
  // Shifter; the amount comes from the field or the low five source bits.
  wire is_var = is_shl_var || is_sra_var;
  wire [4:0] shamt = is_var ? first_source_data[4:0] : shift_amount_field;
  // Only the low word is used, so odd upper halves cannot disturb the result.
  wire [31:0] shl_word = second_source_data[31:0] << shamt;
  wire [31:0] sra_word = $signed(second_source_data[31:0]) >>> shamt;

  // Compare operands; the 65-bit difference holds the true order.
  wire cmp_imm = is_less_than_signed_imm_op || is_less_than_unsigned_imm_op;
  wire [63:0] cmp_b = cmp_imm ? imm_sext : second_source_data;
  wire cmp_unsigned = is_less_than_unsigned_op || is_less_than_unsigned_imm_op;
  wire [63:0] cmp_a = first_source_data;
  // In 32-bit mode only the low words compare; the sign bit sits at 31.
  wire [64:0] ext_a = mode_64 ? {cmp_unsigned ? 1'b0 : cmp_a[63], cmp_a}
                              : {{33{cmp_unsigned ? 1'b0 : cmp_a[31]}}, cmp_a[31:0]};
  wire [64:0] ext_b = mode_64 ? {cmp_unsigned ? 1'b0 : cmp_b[63], cmp_b}
                              : {{33{cmp_unsigned ? 1'b0 : cmp_b[31]}}, cmp_b[31:0]};
  wire less = $signed(ext_a) < $signed(ext_b);

  // Result selection.
  wire is_cmp = is_slt || is_less_than_unsigned_op || is_less_than_signed_imm_op || is_less_than_unsigned_imm_op;
  wire is_shl = is_shl_imm || is_shl_var;
  wire is_sra = is_sra_imm || is_sra_var;
  wire [63:0] next_result = is_shl ? word_ext(shl_word, mode_64) :
                            is_sra ? word_ext(sra_word, mode_64) :
                            {63'h0, less};
  wire next_result_valid = is_cmp || is_shl || is_sra;

  ////////////////////////////////////////////////////////////////////////////
  // Store address and lane forming.
  wire [63:0] raw_addr = first_source_data + imm_sext;
  wire [63:0] eff_addr = mode_64 ? raw_addr : word_ext(raw_addr[31:0], 1'b0);
  wire [2:0] byte_sel = eff_addr[2:0];
  wire sdr_reserved = is_sdr && !mode_64 && !mode_kernel;
  wire sh_misaligned = is_sh && eff_addr[0];
  wire [5:0] sdr_shift = {byte_sel, 3'h0};
  wire [63:0] sdr_data = second_source_data << sdr_shift;
  wire [63:0] sh_data = {4{second_source_data[15:0]}};
  wire next_store_valid = (is_sh && !sh_misaligned) || (is_sdr && !sdr_reserved);
  // Big-endian memory takes the doubleword base; little-endian keeps the byte offset.
  wire [2:0] sdr_offset = memory_big_endian_flag ? 3'h0 : byte_sel;
  wire [2:0] next_type = is_sdr ? (ACC_DOUBLE - byte_sel) : ACC_HALF;
  wire [2:0] next_offset = is_sdr ? sdr_offset : byte_sel;
  wire [63:0] next_data = is_sdr ? sdr_data : sh_data;

  ////////////////////////////////////////////////////////////////////////////
  // Result registers.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      result_valid <= 1'b0;
      result <= RES_RESET;
    end else begin
      result_valid <= next_result_valid;
      result <= next_result;
    end
  end

  // Store and exception registers; exceptions are one-cycle pulses.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      store_valid <= 1'b0;
      store_addr <= RES_RESET;
      store_data <= RES_RESET;
      store_type <= 3'h0;
      store_offset <= 3'h0;
      exc_addr_error <= 1'b0;
      exc_reserved <= 1'b0;
    end else begin
      store_valid <= next_store_valid;
      store_addr <= eff_addr;
      store_data <= next_data;
      store_type <= next_type;
      store_offset <= next_offset;
      exc_addr_error <= sh_misaligned;
      exc_reserved <= sdr_reserved;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  a_sh_odd_nowrite: assert property (@(posedge clk_sys) disable iff (!rstn)
    sh_misaligned |=> exc_addr_error && !store_valid) else $error("odd halfword stored");
  a_sdr_reserved: assert property (@(posedge clk_sys) disable iff (!rstn)
    sdr_reserved |=> exc_reserved && !store_valid) else $error("reserved store done");
  a_sdr_type: assert property (@(posedge clk_sys) disable iff (!rstn)
    (is_sdr && !sdr_reserved) |=> store_type == 3'h7 - store_addr[2:0])
    else $error("bad access type");
  a_shl_sext: assert property (@(posedge clk_sys) disable iff (!rstn)
    (is_shl && mode_64) |=> result[63:32] == {32{result[31]}}) else $error("no sign ext");
  a_shl_zero_fill: assert property (@(posedge clk_sys) disable iff (!rstn)
    (is_shl_var && first_source_data[4:0] == 5'h1f) |=> result[30:0] == 31'h0)
    else $error("low bits not zero");
  a_slt_value: assert property (@(posedge clk_sys) disable iff (!rstn)
    (is_slt && mode_64) |=> result == {63'h0, $past($signed(first_source_data) <
      $signed(second_source_data))}) else $error("signed compare wrong");
  a_less_than_unsigned_op_value: assert property (@(posedge clk_sys) disable iff (!rstn)
    (is_less_than_unsigned_op && mode_64) |=> result == {63'h0, $past(first_source_data <
      second_source_data)}) else $error("unsigned compare wrong");
  a_sra_fill: assert property (@(posedge clk_sys) disable iff (!rstn)
    (is_sra_imm && shift_amount_field == 5'h1f) |=> result[31:0] == {32{$past(
      second_source_data[31])}}) else $error("sign fill wrong");
  a_sh_lane: assert property (@(posedge clk_sys) disable iff (!rstn)
    (is_sh && !sh_misaligned) |=> store_valid && store_data[15:0] == $past(
      second_source_data[15:0])) else $error("halfword data wrong");

  // Further checks; each one covers a case that the checks above leave open.
  // An opcode outside the decoded set must leave every output pulse low.
  a_unknown_quiet: assert property (@(posedge clk_sys) disable iff (!rstn)
    (issue_valid && !next_result_valid && !is_sh && !is_sdr) |=>
      !result_valid && !store_valid && !exc_addr_error && !exc_reserved)
    else $error("unknown opcode answered");
  // Shifts always give a result and never raise an exception.
  a_shift_no_trap: assert property (@(posedge clk_sys) disable iff (!rstn)
    (is_shl || is_sra) |=> result_valid && !exc_addr_error && !exc_reserved)
    else $error("shift trapped");
  // Compares give a single bit and never trap, even when the difference overflows.
  a_cmp_binary: assert property (@(posedge clk_sys) disable iff (!rstn)
    is_cmp |=> result_valid && result[63:1] == 63'h0 && !exc_addr_error && !exc_reserved)
    else $error("compare not binary");
  // Signed immediate compare against the sign-extended immediate.
  a_less_than_signed_imm_op_value: assert property (@(posedge clk_sys) disable iff (!rstn)
    (is_less_than_signed_imm_op && mode_64) |=> result[0] == $past($signed(first_source_data) <
      $signed({{48{instr[15]}}, instr[15:0]}))) else $error("signed imm compare wrong");
  // Unsigned immediate compare still sign-extends the immediate first.
  a_less_than_unsigned_imm_op_value: assert property (@(posedge clk_sys) disable iff (!rstn)
    (is_less_than_unsigned_imm_op && mode_64) |=> result[0] == $past(first_source_data <
      {{48{instr[15]}}, instr[15:0]})) else $error("unsigned imm compare wrong");
  // Variable arithmetic shift by 31 leaves only copies of the sign bit.
  a_shift_right_arith_var_op_fill: assert property (@(posedge clk_sys) disable iff (!rstn)
    (is_sra_var && first_source_data[4:0] == 5'h1f) |=> result[31:0] == {32{$past(
      second_source_data[31])}}) else $error("variable sign fill wrong");
  // In 64-bit mode a zero left shift truncates the source to its low word and sign-extends it.
  a_shl_zero_amt: assert property (@(posedge clk_sys) disable iff (!rstn)
    (is_shl_imm && shift_amount_field == 5'h0 && mode_64) |=> result == {{32{$past(
      second_source_data[31])}}, $past(second_source_data[31:0])}) else $error("zero shift");
  // Little-endian memory receives the low address bits as offset.
  a_sdr_offset: assert property (@(posedge clk_sys) disable iff (!rstn)
    (is_sdr && !sdr_reserved && !memory_big_endian_flag) |=>
      store_offset == store_addr[2:0]) else $error("bad store offset");
  // Halfword stores always use the halfword access type.
  a_sh_type: assert property (@(posedge clk_sys) disable iff (!rstn)
    (is_sh && !sh_misaligned) |=> store_type == ACC_HALF) else $error("bad halfword type");

endmodule // scs_exec

// >>> hw/scs_pkg.sv
// Package for the shift, compare and store execution datapath.
// Assumes a single core clock domain and a decoded 32-bit instruction word.
package scs_pkg;
  // Primary opcodes.
  localparam logic [5:0] OP_SPECIAL = 6'h00;
  localparam logic [5:0] OP_SLT_IMM = 6'h0a;
  localparam logic [5:0] OP_LESS_THAN_UNSIGNED_OP_IMM = 6'h0b;
  localparam logic [5:0] OP_STORE_HALF = 6'h29;
  localparam logic [5:0] OP_STORE_DBL_RIGHT = 6'h2d;
  // Function codes of the register group.
  localparam logic [5:0] FN_SHL_IMM = 6'h00;
  localparam logic [5:0] FN_SRA_IMM = 6'h03;
  localparam logic [5:0] FN_SHL_VAR = 6'h04;
  localparam logic [5:0] FN_SRA_VAR = 6'h07;
  localparam logic [5:0] FN_SLT = 6'h2a;
  localparam logic [5:0] FN_LESS_THAN_UNSIGNED_OP = 6'h2b;
  // Instruction field positions.
  localparam int OPC_LSB = 26;
  localparam int FS_LSB = 21;
  localparam int SS_LSB = 16;
  localparam int SA_LSB = 6;
  // Access type of a full doubleword and the halfword access type.
  localparam logic [2:0] ACC_DOUBLE = 3'h7;
  localparam logic [2:0] ACC_HALF = 3'h1;
  // Reset value of the result registers.
  localparam logic [63:0] RES_RESET = 64'h0;
endpackage

// >>> tb/scs_store_sink.sv
// Store path model: accepts every store pulse and tallies bytes written.
// Assumes one-cycle store pulses on the core clock.
`timescale 1ns/1ps
module scs_store_sink (
  input wire logic clk_sys, // Core clock.
  input wire logic rstn, // Synchronous reset, active low.
  input wire logic store_valid, // Store request pulse.
  input wire logic [2:0] store_type, // Access type.
  output logic [15:0] byte_total // Bytes written since reset.
);
  // Type n writes n plus one bytes; the sink never stalls, so no handshake.
  always_ff @(posedge clk_sys) begin
    if (!rstn) byte_total <= 16'h0;
    else if (store_valid) byte_total <= byte_total + 16'(store_type) + 16'h1;
  end
endmodule // scs_store_sink

// >>> tb/tb_scs_exec.sv
// Self-checking bench for the shift, compare and store stage.
// Assumes one-cycle registered answers and back-to-back issue.
`timescale 1ns/1ps
module tb_scs_exec
  import scs_pkg::*;
;
  typedef struct packed {logic [3:0] f; logic m; logic [63:0] a; logic [63:0] b; logic [5:0] c;} scs_note_t;
  logic clk_sys = 1'b0, rstn = 1'b0, issue_valid = 1'b0, mode_64 = 1'b0, mode_kernel = 1'b0;
  logic [31:0] instr = 32'h0;
  logic be_next = 1'b0, mem_be = 1'b0;
  logic [63:0] rs_d = 64'h0, rt_d = 64'h0, result, store_addr, store_data;
  logic result_valid, store_valid, exc_addr_error, exc_reserved;
  logic [2:0] store_type, store_offset;
  logic [15:0] byte_total, exp_bytes = 16'h0;
  int fail_count = 0, n_tests = 0;
  scs_note_t notes[$];
  scs_note_t obs, e;
  always #12.5 clk_sys = ~clk_sys;
  scs_exec i_scs_exec (.clk_sys(clk_sys), .rstn(rstn), .issue_valid(issue_valid), .instr(instr),
    .first_source_data(rs_d), .second_source_data(rt_d), .mode_64(mode_64),
    .mode_kernel(mode_kernel), .memory_big_endian_flag(mem_be), .result_valid(result_valid),
    .result(result), .store_valid(store_valid), .store_addr(store_addr), .store_data(store_data),
    .store_type(store_type), .store_offset(store_offset), .exc_addr_error(exc_addr_error),
    .exc_reserved(exc_reserved));
  scs_store_sink i_scs_store_sink (.clk_sys(clk_sys), .rstn(rstn), .store_valid(store_valid),
    .store_type(store_type), .byte_total(byte_total));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [63:0] sx32(input logic [31:0] w);
    return {{32{w[31]}}, w};
  endfunction
  // Boundary operands half the time, so compares see subtraction overflow.
  function automatic logic [63:0] pick();
    logic [63:0] v[4] = '{64'h7fff_ffff_ffff_ffff, 64'h8000_0000_0000_0000, 64'hffff_ffff_8000_0001, 64'h0};
    return $urandom_range(1) ? {$urandom, $urandom} : v[$urandom_range(3)];
  endfunction
  // Drives one instruction at this edge and notes what must come back.
  task automatic issue(input logic [5:0] op, fn, input logic [15:0] imm,
                       input logic [63:0] a, b, input logic m, k);
    logic [63:0] ad, c, la, lc;
    logic [4:0] s;
    scs_note_t n;
    n = '0;
    n.m = m;
    ad = a + {{48{imm[15]}}, imm};
    if (!m) ad = {32'h0, ad[31:0]};
    c = (op == OP_SPECIAL) ? b : {{48{imm[15]}}, imm};
    la = m ? a : sx32(a[31:0]);
    lc = m ? c : sx32(c[31:0]);
    s = fn[2] ? a[4:0] : imm[4:0];
    if (op == OP_STORE_HALF) begin
      n.f = ad[0] ? 4'h2 : 4'h4;
      if (!ad[0]) n.a = ad;
      if (!ad[0]) n.b = {4{b[15:0]}};
      if (!ad[0]) n.c = {ACC_HALF, ad[2:0]};
    end else if (op == OP_STORE_DBL_RIGHT) begin
      n.f = (!m && !k) ? 4'h1 : 4'h4;
      if (n.f == 4'h4) n.a = ad;
      if (n.f == 4'h4) n.b = b << (8 * ad[2:0]);
      if (n.f == 4'h4) n.c = {3'h7 - ad[2:0], be_next ? 3'h0 : ad[2:0]};
    end else begin
      n.f = 4'h8;
      case ({op, fn})
        {OP_SPECIAL, FN_SHL_IMM}, {OP_SPECIAL, FN_SHL_VAR}: n.a = sx32(b[31:0] << s);
        {OP_SPECIAL, FN_SRA_IMM}, {OP_SPECIAL, FN_SRA_VAR}: n.a = sx32($signed(b[31:0]) >>> s);
        {OP_SPECIAL, FN_SLT}, {OP_SLT_IMM, 6'h00}: n.a = 64'($signed(la) < $signed(lc));
        {OP_SPECIAL, FN_LESS_THAN_UNSIGNED_OP}, {OP_LESS_THAN_UNSIGNED_OP_IMM, 6'h00}: n.a = 64'(la < lc);
        default: n.f = 4'h0;
      endcase
    end
    instr <= (op == OP_SPECIAL) ? {op, fn[1] ? 5'h0 : 5'h1, 5'h2, 5'h3, imm[4:0], fn} : {op, 10'h22, imm};
    rs_d <= a;
    rt_d <= b;
    mode_64 <= m;
    mode_kernel <= k;
    mem_be <= be_next;
    issue_valid <= 1'b1;
    if (n.f != 4'h0) notes.push_back(n);
    if (n.f == 4'h4) exp_bytes += 16'(n.c[5:3]) + 16'h1;
    @(posedge clk_sys);
  endtask
  task automatic summarize();
    if (fail_count == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Watches the outputs once settled and checks each answer against the oldest note.
  always @(posedge clk_sys) begin
    #1;
    obs = '0;
    obs.f = {result_valid, store_valid, exc_addr_error, exc_reserved};
    if (obs.f !== 4'h0) begin
      e = (notes.size() != 0) ? notes.pop_front() : '0;
      obs.m = e.m;
      obs.a = result_valid ? result : (store_valid ? store_addr : 64'h0);
      obs.b = store_valid ? store_data : 64'h0;
      obs.c = store_valid ? {store_type, store_offset} : 6'h0;
      if (result_valid && !e.m) obs.a[63:32] = 32'h0;
      if (result_valid && !e.m) e.a[63:32] = 32'h0;
      n_tests++;
      if (obs !== e) begin
        fail_count++;
        $display("ERROR t=%0t got=%h exp=%h", $time, obs, e);
      end
    end
  end
  // Reset, then every right-store offset in 64-bit user, 32-bit kernel and 32-bit user modes, then a random mix back to back.
  initial begin
    int op_i;
    logic [63:0] a, b;
    logic [5:0] ops[10] = '{OP_SPECIAL, OP_SPECIAL, OP_SPECIAL, OP_SPECIAL, OP_SPECIAL,
                           OP_SPECIAL, OP_SLT_IMM, OP_LESS_THAN_UNSIGNED_OP_IMM, OP_STORE_HALF, 6'h3e};
    logic [5:0] fns[10] = '{FN_SHL_IMM, FN_SRA_IMM, FN_SHL_VAR, FN_SRA_VAR, FN_SLT, FN_LESS_THAN_UNSIGNED_OP,
                           6'h00, 6'h00, 6'h00, 6'h00};
    void'($urandom(22));
    repeat (6) @(posedge clk_sys);
    rstn <= 1'b1;
    for (int i = 0; i < 32; i++) begin
      be_next = (i >= 24);
      issue(OP_STORE_DBL_RIGHT, 6'h0, 16'(i % 8), 64'h1000, {$urandom, $urandom}, i < 8 || i >= 24, i >= 8 && i < 16);
    end
    be_next = 1'b0;
    for (int i = 0; i < 400; i++) begin
      op_i = $urandom_range(9);
      a = pick();
      b = pick();
      if (op_i == 1 || op_i == 3) b = sx32(b[31:0]);
      issue(ops[op_i], fns[op_i], 16'($urandom), a, b, 1'($urandom), 1'($urandom));
    end
    issue_valid <= 1'b0;
    repeat (3) @(posedge clk_sys);
    n_tests++;
    if (notes.size() != 0 || byte_total !== exp_bytes) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, byte_total, exp_bytes);
    end
    summarize();
  end
endmodule // tb_scs_exec
